// >>> shared/acc_pkg.sv
package acc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 40;
  localparam int T_CONV_CH_NS   = 480;  // one channel's conversion
  localparam int T_ACQ_NS       = 320;  // self-timed acquisition
  localparam int T_START_LOW_NS = 80;   // host start strobe width
  localparam int CONV_CH_CYC    = (T_CONV_CH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_CYC        = (T_ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_LOW_CYC  = (T_START_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W          = 8;

  // ----------------------------------------------------------------
  // data
  // ----------------------------------------------------------------
  localparam int DATA_W         = 16;
  localparam int SER_BITS       = 2 * DATA_W;
  localparam int SER_CNT_W      = 6;

  // ----------------------------------------------------------------
  // controller register map (word offsets of the plain port)
  // ----------------------------------------------------------------
  localparam int ADDR_W         = 4;
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_CMD      = 4'h1;
  localparam logic [3:0] REG_STATUS   = 4'h2;
  localparam logic [3:0] REG_RESULT_A = 4'h3;
  localparam logic [3:0] REG_RESULT_B = 4'h4;

  // ctrl fields
  localparam int CTRL_IMPULSE   = 0;
  localparam int CTRL_SERIAL    = 1;
  localparam int CTRL_PAIR      = 2;
  localparam int CTRL_PDOWN     = 3;
  localparam int CTRL_RESET     = 4;
  localparam int CTRL_FREE_RUN  = 5;
  localparam int CTRL_A_FIRST   = 6;
  localparam int CTRL_W         = 7;
  localparam logic [6:0] CTRL_RESET_VAL = 7'h00;

  // cmd fields
  localparam int CMD_START      = 0;
  localparam int CMD_READ       = 1;

  // status fields
  localparam int STAT_BUSY      = 0;
  localparam int STAT_VALID     = 1;
  localparam int STAT_READING   = 2;
  localparam int STAT_STARTING  = 3;

endpackage

// >>> shared/acc_link_if.sv
`timescale 1ns/1ps
interface acc_link_if;
  // host to converter
  logic                          convert_start_n;
  logic                          pair_select;
  logic                          power_down_in;
  logic                          impulse_mode;
  logic                          conv_reset;
  logic                          cs_n;
  logic                          rd_n;
  logic                          chan_a_select;
  logic                          serial_parallel_select;
  // converter to host
  logic                          busy;
  logic [acc_pkg::DATA_W-1:0]    data_out;
  logic                          data_oe;

  modport dev (
    input  convert_start_n, pair_select, power_down_in, impulse_mode, conv_reset,
    input  cs_n, rd_n, chan_a_select, serial_parallel_select,
    output busy, data_out, data_oe
  );
  modport host (
    output convert_start_n, pair_select, power_down_in, impulse_mode, conv_reset,
    output cs_n, rd_n, chan_a_select, serial_parallel_select,
    input  busy, data_out, data_oe
  );
endinterface

// >>> design/acc_conv_dev.sv
`timescale 1ns/1ps
module acc_conv_dev #(
  parameter int CONV_CYC = acc_pkg::CONV_CH_CYC,
  parameter int ACQ_CYCS = acc_pkg::ACQ_CYC
) (
  // clock and reset
  input  wire logic                       core_clk_i,
  input  wire logic                       reset_i,
  // link
  acc_link_if.dev                         link,
  // sampled analog codes, straight binary
  input  wire logic [acc_pkg::DATA_W-1:0] pair1_a_i,
  input  wire logic [acc_pkg::DATA_W-1:0] pair1_b_i,
  input  wire logic [acc_pkg::DATA_W-1:0] pair2_a_i,
  input  wire logic [acc_pkg::DATA_W-1:0] pair2_b_i,
  // status
  input  wire logic                       unused_i,
  output logic                            low_power_o,
  output logic                            end_of_conv_a_o
);

  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ACC_IDLE, ACC_CONV_A, ACC_CONV_B, ACC_ACQ} acc_state_t;

  acc_state_t                          state_r;
  logic [acc_pkg::CNT_W-1:0]           cnt_r;
  logic                                start_n_d_r;
  logic                                pair_r;
  logic [acc_pkg::DATA_W-1:0]          samp_a_r;
  logic [acc_pkg::DATA_W-1:0]          samp_b_r;
  logic [acc_pkg::DATA_W-1:0]          res_a_r;
  logic [acc_pkg::DATA_W-1:0]          res_b_r;
  logic [acc_pkg::SER_BITS-1:0]        shift_r;
  logic [acc_pkg::DATA_W-1:0]          data_r;
  logic                                abort;
  logic                                start_fall;
  logic                                auto_go;
  logic                                drive;
  logic                                cnt_done;

  localparam logic [acc_pkg::CNT_W-1:0] CONV_LAST = acc_pkg::CNT_W'(CONV_CYC - 1);
  localparam logic [acc_pkg::CNT_W-1:0] ACQ_LAST  = acc_pkg::CNT_W'(ACQ_CYCS - 1);

  // ----------------------------------------------------------------
  // control terms
  // ----------------------------------------------------------------
  // either the core reset or the converter's own reset pin aborts
  assign abort      = reset_i | link.conv_reset;
  // edge from the pin alone, no gating by the read port
  assign start_fall = start_n_d_r & ~link.convert_start_n;
  // a start held low while idle only restarts in impulse mode
  assign auto_go    = link.impulse_mode & ~link.convert_start_n;
  assign drive      = ~link.cs_n & ~link.rd_n & ~link.conv_reset;
  assign cnt_done   = (state_r == ACC_ACQ) ? (cnt_r == ACQ_LAST) : (cnt_r == CONV_LAST);

  // start pin history for edge detection
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      start_n_d_r <= 1'b1;
    end else begin
      start_n_d_r <= link.convert_start_n;
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  // once converting, start edges and power-down are not looked at
  always_ff @(posedge core_clk_i) begin
    if (abort) begin
      state_r <= ACC_IDLE;
      cnt_r   <= '0;
    end else begin
      unique case (state_r)
        ACC_IDLE: begin
          cnt_r <= '0;
          if (!link.power_down_in && start_fall) begin
            state_r <= ACC_CONV_A;
          end else if (!link.power_down_in && auto_go) begin
            state_r <= ACC_ACQ;
          end
        end
        ACC_ACQ: begin
          if (cnt_done) begin
            cnt_r   <= '0;
            state_r <= ACC_CONV_A;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ACC_CONV_A: begin
          if (cnt_done) begin
            cnt_r   <= '0;
            state_r <= ACC_CONV_B;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ACC_CONV_B: begin
          if (cnt_done) begin
            cnt_r <= '0;
            // keep running by itself while the start pin stays low in impulse mode
            if (auto_go) begin
              state_r <= ACC_ACQ;
            end else begin
              state_r <= ACC_IDLE;
            end
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sampling
  // ----------------------------------------------------------------
  // pair chosen once at hold; both channels take the same pair
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pair_r   <= 1'b0;
      samp_a_r <= '0;
      samp_b_r <= '0;
    end else if ((state_r == ACC_IDLE && start_fall && !link.power_down_in && !link.conv_reset) ||
                 (state_r == ACC_ACQ && cnt_done && !link.conv_reset)) begin
      pair_r   <= link.pair_select;
      samp_a_r <= link.pair_select ? pair2_a_i : pair1_a_i;
      samp_b_r <= link.pair_select ? pair2_b_i : pair1_b_i;
    end
  end

  // ----------------------------------------------------------------
  // results
  // ----------------------------------------------------------------
  // channel A result is usable on the parallel port as soon as its own conversion ends
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      res_a_r <= '0;
      res_b_r <= '0;
    end else if (!abort && cnt_done) begin
      if (state_r == ACC_CONV_A) begin
        res_a_r <= samp_a_r;
      end
      if (state_r == ACC_CONV_B) begin
        res_b_r <= samp_b_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // serial word and data port
  // ----------------------------------------------------------------
  // serial word is refreshed only after channel B is done
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      shift_r <= '0;
    end else if (!abort && cnt_done && state_r == ACC_CONV_B) begin
      shift_r <= link.chan_a_select ? {res_a_r, samp_b_r} : {samp_b_r, res_a_r};
    end else if (drive && link.serial_parallel_select) begin
      shift_r <= {shift_r[acc_pkg::SER_BITS-2:0], shift_r[acc_pkg::SER_BITS-1]};
    end
  end

  // registered bus word; serial data rides on bit 0 of the same pins
  always_ff @(posedge core_clk_i) begin
    if (abort) begin
      data_r <= '0;
    end else if (link.serial_parallel_select) begin
      data_r <= {{(acc_pkg::DATA_W-1){1'b0}}, shift_r[acc_pkg::SER_BITS-1]};
    end else begin
      data_r <= link.chan_a_select ? res_a_r : res_b_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.busy        = (state_r == ACC_CONV_A) || (state_r == ACC_CONV_B);
  assign link.data_out    = data_r;
  // floats whenever either strobe is high or reset is held
  assign link.data_oe     = drive & ~reset_i;
  // power drops between conversions in impulse mode only; the port logic is not gated
  assign low_power_o      = link.impulse_mode & ~link.busy;
  assign end_of_conv_a_o  = (state_r == ACC_CONV_B);

endmodule

// >>> design/acc_conv_host.sv
`timescale 1ns/1ps
module acc_conv_host #(
  parameter int START_CYC = acc_pkg::START_LOW_CYC
) (
  // clock and reset
  input  wire logic                            core_clk_i,
  input  wire logic                            reset_i,
  // register port
  input  wire logic [acc_pkg::ADDR_W-1:0]      addr_i,
  input  wire logic [31:0]                     wdata_i,
  input  wire logic                            wr_i,
  input  wire logic                            rd_i,
  output logic      [31:0]                     rdata_o,
  // link
  acc_link_if.host                             link
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ACC_H_IDLE, ACC_H_PAR_A, ACC_H_PAR_B, ACC_H_SER} acc_hstate_t;

  acc_hstate_t                       hstate_r;
  logic [acc_pkg::CTRL_W-1:0]        ctrl_r;
  logic [acc_pkg::CNT_W-1:0]         start_cnt_r;
  logic [acc_pkg::SER_CNT_W-1:0]     rd_cnt_r;
  logic [acc_pkg::DATA_W-1:0]        res_a_r;
  logic [acc_pkg::DATA_W-1:0]        res_b_r;
  logic [acc_pkg::SER_BITS-1:0]      ser_r;
  logic                              valid_r;
  logic                              busy_d_r;
  logic [31:0]                       rdata_r;
  logic                              cmd_wr;

  localparam logic [acc_pkg::CNT_W-1:0]     START_LAST = acc_pkg::CNT_W'(START_CYC);
  localparam logic [acc_pkg::SER_CNT_W-1:0] SER_LAST   = acc_pkg::SER_CNT_W'(acc_pkg::SER_BITS);

  assign cmd_wr = wr_i && (addr_i == acc_pkg::REG_CMD);

  // control register
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ctrl_r <= acc_pkg::CTRL_RESET_VAL;
    end else if (wr_i && addr_i == acc_pkg::REG_CTRL) begin
      ctrl_r <= wdata_i[acc_pkg::CTRL_W-1:0];
    end
  end

  // start strobe; free-run together with impulse mode keeps it low after the first edge
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      start_cnt_r <= '0;
    end else if (cmd_wr && wdata_i[acc_pkg::CMD_START]) begin
      start_cnt_r <= START_LAST;
    end else if (start_cnt_r != '0) begin
      start_cnt_r <= start_cnt_r - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read sequencer
  // ----------------------------------------------------------------
  // reads are started after busy falls, or at once on a read command, which can land in a conversion
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      hstate_r <= ACC_H_IDLE;
      rd_cnt_r <= '0;
      res_a_r  <= '0;
      res_b_r  <= '0;
      ser_r    <= '0;
      valid_r  <= 1'b0;
      busy_d_r <= 1'b0;
    end else begin
      busy_d_r <= link.busy;
      unique case (hstate_r)
        ACC_H_IDLE: begin
          rd_cnt_r <= '0;
          if ((busy_d_r && !link.busy) || (cmd_wr && wdata_i[acc_pkg::CMD_READ])) begin
            hstate_r <= ctrl_r[acc_pkg::CTRL_SERIAL] ? ACC_H_SER : ACC_H_PAR_A;
          end
        end
        ACC_H_PAR_A: begin
          rd_cnt_r <= rd_cnt_r + 1'b1;
          if (rd_cnt_r == 6'd1) begin
            res_a_r  <= link.data_out;
            rd_cnt_r <= '0;
            hstate_r <= ACC_H_PAR_B;
          end
        end
        ACC_H_PAR_B: begin
          rd_cnt_r <= rd_cnt_r + 1'b1;
          if (rd_cnt_r == 6'd1) begin
            res_b_r  <= link.data_out;
            valid_r  <= 1'b1;
            hstate_r <= ACC_H_IDLE;
          end
        end
        ACC_H_SER: begin
          rd_cnt_r <= rd_cnt_r + 1'b1;
          if (rd_cnt_r != '0) begin
            ser_r <= {ser_r[acc_pkg::SER_BITS-2:0], link.data_out[0]};
          end
          if (rd_cnt_r == SER_LAST) begin
            valid_r  <= 1'b1;
            hstate_r <= ACC_H_IDLE;
          end
        end
      endcase
      if (hstate_r == ACC_H_SER && rd_cnt_r == SER_LAST) begin
        res_a_r <= ctrl_r[acc_pkg::CTRL_A_FIRST] ? {ser_r[acc_pkg::SER_BITS-2:acc_pkg::DATA_W-1]}
                                                 : {ser_r[acc_pkg::DATA_W-2:0], link.data_out[0]};
        res_b_r <= ctrl_r[acc_pkg::CTRL_A_FIRST] ? {ser_r[acc_pkg::DATA_W-2:0], link.data_out[0]}
                                                 : {ser_r[acc_pkg::SER_BITS-2:acc_pkg::DATA_W-1]};
      end
    end
  end

  // register read data, one cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_r <= '0;
    end else if (rd_i) begin
      unique case (addr_i)
        acc_pkg::REG_CTRL:     rdata_r <= {25'h0, ctrl_r};
        acc_pkg::REG_STATUS:   rdata_r <= {28'h0, (start_cnt_r != '0), (hstate_r != ACC_H_IDLE), valid_r, link.busy};
        acc_pkg::REG_RESULT_A: rdata_r <= {16'h0, res_a_r};
        acc_pkg::REG_RESULT_B: rdata_r <= {16'h0, res_b_r};
        default:               rdata_r <= '0;
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  // ----------------------------------------------------------------
  // link drive
  // ----------------------------------------------------------------
  assign rdata_o                     = rdata_r;
  assign link.convert_start_n        = ~((start_cnt_r != '0) ||
                                         (ctrl_r[acc_pkg::CTRL_FREE_RUN] && ctrl_r[acc_pkg::CTRL_IMPULSE]));
  assign link.pair_select            = ctrl_r[acc_pkg::CTRL_PAIR];
  assign link.power_down_in          = ctrl_r[acc_pkg::CTRL_PDOWN];
  assign link.impulse_mode           = ctrl_r[acc_pkg::CTRL_IMPULSE];
  assign link.conv_reset             = ctrl_r[acc_pkg::CTRL_RESET];
  assign link.serial_parallel_select = ctrl_r[acc_pkg::CTRL_SERIAL];
  // strobes only during a read: the bus is never parked driven
  assign link.cs_n                   = (hstate_r == ACC_H_IDLE);
  assign link.rd_n                   = (hstate_r == ACC_H_IDLE);
  // serial order must stand before reads: the device loads its word at end of B
  assign link.chan_a_select          = ctrl_r[acc_pkg::CTRL_SERIAL] ? ctrl_r[acc_pkg::CTRL_A_FIRST]
                                                                    : (hstate_r != ACC_H_PAR_B);

endmodule

// >>> dv/acc_link_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// link protocol checker, sits beside the interface
// ----------------------------------------------------------------
module acc_link_monitor #(
  parameter int CONV_CYC = acc_pkg::CONV_CH_CYC
) (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  // host to converter
  input  wire logic convert_start_n,
  input  wire logic power_down_in,
  input  wire logic impulse_mode,
  input  wire logic conv_reset,
  input  wire logic cs_n,
  input  wire logic rd_n,
  // converter to host
  input  wire logic busy,
  input  wire logic data_oe
);
  logic [7:0] busy_cnt_r;
  logic [7:0] busy_cnt_nxt;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  // length of the current busy run, so a cut-short conversion shows up
  always_comb busy_cnt_nxt = busy ? busy_cnt_r + 8'h01 : 8'h00;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      busy_cnt_r <= 8'h00;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end

  a_oe_gating: assert property (data_oe == (!cs_n && !rd_n && !conv_reset))
    else $error("data enable disagrees with select, read and reset");
  a_busy_width: assert property ($fell(busy) && !$past(conv_reset) |-> busy_cnt_r == 2 * CONV_CYC)
    else $error("busy width is not two channel conversions");
  a_no_abort: assert property (busy && busy_cnt_r < 2 * CONV_CYC - 1 && !conv_reset |=> busy)
    else $error("conversion ended early");
  a_reset_abort: assert property (conv_reset |=> !busy)
    else $error("converter reset did not abort");
  a_start_busy: assert property ($fell(convert_start_n) && !busy && !power_down_in && !conv_reset |=> busy)
    else $error("start edge did not begin a conversion");
  a_no_spurious: assert property (!busy && !$fell(convert_start_n) && !(impulse_mode && !convert_start_n)
    |=> !busy)
    else $error("conversion began without a start edge");
  a_auto_restart: assert property ($fell(busy) && impulse_mode && !convert_start_n && !power_down_in
    && !$past(conv_reset) |-> !busy [*4] ##[1:8] busy)
    else $error("held start did not restart after acquisition");
  a_pdown_block: assert property (!busy && power_down_in |=> !busy)
    else $error("conversion began while powered down");
endmodule

// >>> dv/adc_conv_ctrl_host_port_test.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// bench: host end and converter end joined by the link
// ----------------------------------------------------------------
module adc_conv_ctrl_host_port_test;
  localparam logic [63:0] CODES = 64'h0000_ffff_8000_7fff;
  logic        core_clk_i;
  logic        reset_i;
  logic [3:0]  addr_i;
  logic [31:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rdata_o;
  logic [15:0] pair1_a, pair1_b, pair2_a, pair2_b;
  logic        low_power_o;
  logic        end_of_conv_a_o;
  int          bad_count;
  int          tests_run;

  acc_link_if link ();
  acc_conv_host u_acc_conv_host (.core_clk_i(core_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(link));
  acc_conv_dev u_acc_conv_dev (.core_clk_i(core_clk_i), .reset_i(reset_i), .link(link), .pair1_a_i(pair1_a),
    .pair1_b_i(pair1_b), .pair2_a_i(pair2_a), .pair2_b_i(pair2_b), .unused_i(1'b0),
    .low_power_o(low_power_o), .end_of_conv_a_o(end_of_conv_a_o));
  acc_link_monitor u_acc_link_monitor (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .convert_start_n(link.convert_start_n), .power_down_in(link.power_down_in), .impulse_mode(link.impulse_mode),
    .conv_reset(link.conv_reset), .cs_n(link.cs_n), .rd_n(link.rd_n), .busy(link.busy), .data_oe(link.data_oe));

  always #(acc_pkg::CLK_PERIOD_NS / 2) core_clk_i = ~core_clk_i;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i   <= 1'b0;
    @(negedge core_clk_i);
    d = rdata_o;
  endtask

  // bounded wait; a hang ends the run
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (link.busy !== lvl && n < 300) begin
      @(negedge core_clk_i);
      n++;
    end
    if (n == 300) begin
      chk(32'h0, 32'h1, "busy wait ran out");
      test_done();
    end
  endtask

  task automatic count_rises(input int cyc, output int cnt);
    logic prev;
    cnt  = 0;
    prev = link.busy;
    repeat (cyc) begin
      @(negedge core_clk_i);
      if (link.busy === 1'b1 && prev === 1'b0) cnt++;
      prev = link.busy;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    reg_rd(acc_pkg::REG_CTRL, d);
    chk(d, {25'h0, acc_pkg::CTRL_RESET_VAL}, "ctrl after reset");
    reg_wr(4'hf, 32'hffff_ffff);
    reg_rd(4'hf, d);
    chk(d, 32'h0, "unmapped read");
    reg_rd(acc_pkg::REG_STATUS, d);
    chk({31'h0, d[acc_pkg::STAT_BUSY]}, 32'h0, "idle busy flag");
    chk({31'h0, link.data_oe}, 32'h0, "bus released");
    $display("test reset done");
  endtask

  // every pair, port and first-channel choice; codes move once sampled
  task automatic t_convert();
    logic [31:0] d;
    for (int i = 0; i < 8; i++) begin
      reg_wr(acc_pkg::REG_CTRL, {25'h0, i[2], 3'h0, i[0], i[1], 1'b0});
      reg_wr(acc_pkg::REG_CMD, 32'h1);
      wait_busy(1'b1);
      @(posedge core_clk_i);
      {pair1_a, pair1_b, pair2_a, pair2_b} <= {4{16'h5a5a}};
      reg_wr(acc_pkg::REG_CMD, 32'h1);
      repeat (2) @(posedge core_clk_i);
      @(negedge core_clk_i);
      chk({31'h0, end_of_conv_a_o}, 32'h0, "channel a phase");
      repeat (9) @(posedge core_clk_i);
      @(negedge core_clk_i);
      chk({31'h0, end_of_conv_a_o}, 32'h1, "channel b phase");
      wait_busy(1'b0);
      repeat (80) @(posedge core_clk_i);
      {pair1_a, pair1_b, pair2_a, pair2_b} <= CODES;
      reg_rd(acc_pkg::REG_RESULT_A, d);
      chk(d, {16'h0, i[0] ? CODES[31:16] : CODES[63:48]}, "result a");
      reg_rd(acc_pkg::REG_RESULT_B, d);
      chk(d, {16'h0, i[0] ? CODES[15:0] : CODES[47:32]}, "result b");
      reg_rd(acc_pkg::REG_STATUS, d);
      chk({30'h0, d[1:0]}, 32'h2, "status after read");
      chk({31'h0, link.data_oe}, 32'h0, "bus released after read");
    end
    $display("test convert done");
  endtask

  task automatic t_abort();
    logic [31:0] d;
    reg_wr(acc_pkg::REG_CTRL, 32'h0);
    reg_wr(acc_pkg::REG_CMD, 32'h1);
    wait_busy(1'b1);
    repeat (4) @(posedge core_clk_i);
    reg_wr(acc_pkg::REG_CTRL, 32'h10);
    // host strobes are low by now, so only the reset gate keeps the bus off
    repeat (3) @(negedge core_clk_i);
    chk({30'h0, link.busy, link.data_oe}, 32'h0, "abort clears busy and bus");
    reg_wr(acc_pkg::REG_CTRL, 32'h0);
    // a forced read after the abort still finds the earlier result
    repeat (4) @(posedge core_clk_i);
    reg_wr(acc_pkg::REG_CMD, 32'h2);
    repeat (6) @(posedge core_clk_i);
    reg_rd(acc_pkg::REG_RESULT_A, d);
    chk(d, {16'h0, CODES[31:16]}, "forced read after abort");
    $display("test abort done");
  endtask

  // power-down blocks a start when idle, not a running conversion
  task automatic t_pdown();
    int n;
    reg_wr(acc_pkg::REG_CTRL, 32'h08);
    reg_wr(acc_pkg::REG_CMD, 32'h1);
    count_rises(40, n);
    chk(n, 32'h0, "start while powered down");
    reg_wr(acc_pkg::REG_CTRL, 32'h0);
    reg_wr(acc_pkg::REG_CMD, 32'h1);
    wait_busy(1'b1);
    reg_wr(acc_pkg::REG_CTRL, 32'h08);
    wait_busy(1'b0);
    reg_wr(acc_pkg::REG_CTRL, 32'h0);
    $display("test power down done");
  endtask

  // inputs stay settled all through the free run
  task automatic t_free_run();
    int n;
    logic [31:0] d;
    reg_wr(acc_pkg::REG_CTRL, 32'h25);
    count_rises(140, n);
    chk({31'h0, n >= 3 && n <= 5}, 32'h1, "impulse restarts");
    wait_busy(1'b0);
    chk({31'h0, low_power_o}, 32'h1, "low power in acquisition");
    wait_busy(1'b1);
    chk({31'h0, low_power_o}, 32'h0, "full power converting");
    reg_wr(acc_pkg::REG_CTRL, 32'h0);
    wait_busy(1'b0);
    reg_wr(acc_pkg::REG_CTRL, 32'h20);
    count_rises(140, n);
    chk(n, 32'h0, "no restart in normal mode");
    reg_rd(acc_pkg::REG_RESULT_A, d);
    chk(d, {16'h0, CODES[31:16]}, "free run result a");
    reg_rd(acc_pkg::REG_RESULT_B, d);
    chk(d, {16'h0, CODES[15:0]}, "free run result b");
    reg_wr(acc_pkg::REG_CTRL, 32'h0);
    $display("test free run done");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    reset_i    = 1'b1;
    addr_i     = 4'h0;
    wdata_i    = 32'h0;
    wr_i       = 1'b0;
    rd_i       = 1'b0;
    bad_count  = 0;
    tests_run  = 0;
    {pair1_a, pair1_b, pair2_a, pair2_b} = CODES;
    repeat (3) @(posedge core_clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_convert();
    t_abort();
    t_pdown();
    t_free_run();
    test_done();
  end
endmodule
